/* clkmon_defines.svh */
// Offsets, field positions and reset values of the input clock monitor registers
`ifndef CLKMON_DEFINES_SVH
`define CLKMON_DEFINES_SVH

`define ADDR_W 8
`define DATA_W 8

`define OFF_DIV4_TOP 8'h34
`define OFF_DIV4_MID 8'h35
`define OFF_DIV4_LOW 8'h36
`define OFF_BAND_12 8'h37
`define OFF_BAND_34 8'h38
`define OFF_ACTIVE 8'h80
`define OFF_ABSENT_LIVE 8'h81
`define OFF_ABSENT_LATCHED 8'h83

`define RST_DIV4_TOP 3'h0
`define RST_DIV4_MID 8'h00
`define RST_DIV4_LOW 8'h09
`define RST_BAND 3'h0

`define DIV_W 19
`define DIV_TOP_W 3
`define BAND_W 3
`define BAND_HI_LSB 3
`define BAND_LO_LSB 0
`define NUM_INPUTS 4
`define ABSENT_W 5
`define ABSENT_REF_BIT 0
`define SEL_W 2
`define BAND_MAX_LEGAL 3'h5

`endif

/* clkmon_pkg.sv */
// Types shared by the input clock monitor register logic
package clkmon_pkg;
   typedef logic [2:0] band_t;
   typedef logic [7:0] byte_t;
   typedef enum logic [2:0] {
      BAND_10_27,
      BAND_25_54,
      BAND_50_105,
      BAND_95_215,
      BAND_190_435,
      BAND_375_710
   } band_e;
endpackage : clkmon_pkg

/* level_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/100ps
module level_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage feeds the second stage only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : level_sync

/* input_clock_monitor_regs.sv */
// Register slice for input divider four, frequency bands, active input and live absent alarms
//
// What this block does
// - Divider four bits 15:8 and 7:0 sit in two read/write bytes, the low one resetting to 0x09.
// - Each three-bit band field picks the monitored range, codes 0 to 5 from 10-27 MHz up to 375-710 MHz.
// - Band byte one holds input two at 5:3 and input one at 2:0, byte two inputs four and three, 7:6 reserved.
// - Active status bits 3 to 0 show whether inputs four to one drive the PLL, 7:4 reserved.
// - An active bit reads 0 when its input is not selected or its live absent alarm is 1.
// - Live absent byte bits 4 to 1 show the current alarm of inputs four to one, 7:5 reserved.
// - Live absent bit 0 shows that the crystal reference signal is absent.
// - Divider four is 19 bits, its top three bits in bits 2:0 of the preceding byte.
// - Each live absent bit sets a latched flag that holds until software writes 0 to it.
`timescale 1ns/100ps
`include "clkmon_defines.svh"
module input_clock_monitor_regs
   import clkmon_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [`ADDR_W-1:0] reg_addr,
   input wire logic [`DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`DATA_W-1:0] reg_rdata,
   input wire logic [`SEL_W-1:0] selected_input,
   input wire logic pll_input_valid,
   input wire logic [`NUM_INPUTS-1:0] input_signal_absent,
   input wire logic refclk_signal_absent,
   output logic [`DIV_W-1:0] input4_divider,
   output logic [`BAND_W-1:0] input1_freq_band,
   output logic [`BAND_W-1:0] input2_freq_band,
   output logic [`BAND_W-1:0] input3_freq_band,
   output logic [`BAND_W-1:0] input4_freq_band,
   output logic [`NUM_INPUTS-1:0] band_legal,
   output logic [`NUM_INPUTS-1:0] active_status,
   output logic [`ABSENT_W-1:0] absent_latched
);

   // Legal band codes only; codes above five name no range
   function automatic logic band_ok(input band_t code);
      band_ok = (code <= `BAND_MAX_LEGAL);
   endfunction : band_ok

   // Byte address match
   function automatic logic hit(input logic [`ADDR_W-1:0] addr, input logic [`ADDR_W-1:0] offset);
      hit = (addr == offset);
   endfunction : hit

   // Two band fields side by side, reserved top bits zero
   function automatic byte_t pack_bands(input band_t hi, input band_t lo);
      pack_bands = {2'h0, hi, lo};
   endfunction : pack_bands

   // ---------------------------------------------------------------
   // Input synchronisation
   // Alarms and the selector come from the monitor and PLL logic on other clocks
   localparam int SYNC_W = `SEL_W + 1 + `NUM_INPUTS + 1;
   logic [SYNC_W-1:0] raw_in;
   logic [SYNC_W-1:0] sync_in;
   logic [`SEL_W-1:0] sel_s;
   logic sel_valid_s;
   logic [`NUM_INPUTS-1:0] in_absent_s;
   logic ref_absent_s;
   logic [`ABSENT_W-1:0] absent_live;

   assign raw_in = {selected_input, pll_input_valid, input_signal_absent, refclk_signal_absent};

   level_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(raw_in),
      .sync_out(sync_in)
   );

   assign sel_s = sync_in[SYNC_W-1 -: `SEL_W];
   assign sel_valid_s = sync_in[`NUM_INPUTS + 1];
   assign in_absent_s = sync_in[`NUM_INPUTS:1];
   assign ref_absent_s = sync_in[`ABSENT_REF_BIT];
   assign absent_live = {in_absent_s, ref_absent_s};

   // ---------------------------------------------------------------
   // Selector filter
   // Selector bits may cross in different cycles; a word is taken only once
   // it has been seen on two edges in a row, at the cost of two cycles
   localparam int SELW_W = `SEL_W + 1;
   logic [SELW_W-1:0] sel_word_s;
   logic [SELW_W-1:0] sel_prev_q;
   logic [SELW_W-1:0] sel_hold_q;
   logic [SELW_W-1:0] sel_hold_d;
   logic sel_steady;
   logic [`SEL_W-1:0] sel_f;
   logic sel_valid_f;

   assign sel_word_s = {sel_s, sel_valid_s};
   assign sel_steady = (sel_word_s == sel_prev_q);
   assign sel_hold_d = sel_steady ? sel_word_s : sel_hold_q;
   assign sel_f = sel_hold_q[SELW_W-1 -: `SEL_W];
   assign sel_valid_f = sel_hold_q[0];

   // Reset leaves no input looking selected
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_prev_q <= '0;
         sel_hold_q <= '0;
      end else begin
         sel_prev_q <= sel_word_s;
         sel_hold_q <= sel_hold_d;
      end
   end

   // ---------------------------------------------------------------
   // Address decode
   logic at_top;
   logic at_mid;
   logic at_low;
   logic at_band12;
   logic at_band34;
   logic at_active;
   logic at_live;
   logic at_latched;

   logic wr_top;
   logic wr_mid;
   logic wr_low;
   logic wr_band12;
   logic wr_band34;
   logic wr_latched;

   assign at_top = hit(reg_addr, `OFF_DIV4_TOP);
   assign at_mid = hit(reg_addr, `OFF_DIV4_MID);
   assign at_low = hit(reg_addr, `OFF_DIV4_LOW);
   assign at_band12 = hit(reg_addr, `OFF_BAND_12);
   assign at_band34 = hit(reg_addr, `OFF_BAND_34);
   assign at_active = hit(reg_addr, `OFF_ACTIVE);
   assign at_live = hit(reg_addr, `OFF_ABSENT_LIVE);
   assign at_latched = hit(reg_addr, `OFF_ABSENT_LATCHED);

   // Active and live status bytes get no write strobe; of the status bytes only the latched byte gets one
   assign wr_top = reg_wr && at_top;
   assign wr_mid = reg_wr && at_mid;
   assign wr_low = reg_wr && at_low;
   assign wr_band12 = reg_wr && at_band12;
   assign wr_band34 = reg_wr && at_band34;
   assign wr_latched = reg_wr && at_latched;

   // ---------------------------------------------------------------
   // Divider four storage
   logic [`DIV_TOP_W-1:0] div_top_q;
   logic [`DATA_W-1:0] div_mid_q;
   logic [`DATA_W-1:0] div_low_q;
   logic [`DIV_TOP_W-1:0] div_top_d;
   logic [`DATA_W-1:0] div_mid_d;
   logic [`DATA_W-1:0] div_low_d;

   // Reserved upper bits of the top byte are not stored at all
   assign div_top_d = wr_top ? reg_wdata[`DIV_TOP_W-1:0] : div_top_q;
   assign div_mid_d = wr_mid ? reg_wdata : div_mid_q;
   assign div_low_d = wr_low ? reg_wdata : div_low_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_top_q <= `RST_DIV4_TOP;
         div_mid_q <= `RST_DIV4_MID;
         div_low_q <= `RST_DIV4_LOW;
      end else begin
         div_top_q <= div_top_d;
         div_mid_q <= div_mid_d;
         div_low_q <= div_low_d;
      end
   end

   assign input4_divider = {div_top_q, div_mid_q, div_low_q};

   // ---------------------------------------------------------------
   // Frequency band fields, one per input
   band_t band_q [`NUM_INPUTS];
   band_t band_d [`NUM_INPUTS];
   logic [`NUM_INPUTS-1:0] band_legal_q;
   logic [`NUM_INPUTS-1:0] band_legal_d;

   genvar gi;
   generate
      for (gi = 0; gi < `NUM_INPUTS; gi++) begin : g_band
         // Even index is the low field of its byte, odd index the high one
         localparam int LSB = (gi % 2 == 0) ? `BAND_LO_LSB : `BAND_HI_LSB;
         logic wr_this;
         assign wr_this = (gi < 2) ? wr_band12 : wr_band34;
         assign band_d[gi] = wr_this ? band_t'(reg_wdata[LSB +: `BAND_W]) : band_q[gi];
         // Reserved codes are stored as written; the monitor sees them flagged illegal
         assign band_legal_d[gi] = band_ok(band_d[gi]);

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               band_q[gi] <= `RST_BAND;
            end else begin
               band_q[gi] <= band_d[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         band_legal_q <= '1;
      end else begin
         band_legal_q <= band_legal_d;
      end
   end

   assign input1_freq_band = band_q[0];
   assign input2_freq_band = band_q[1];
   assign input3_freq_band = band_q[2];
   assign input4_freq_band = band_q[3];
   assign band_legal = band_legal_q;

   // ---------------------------------------------------------------
   // Active input status
   logic [`NUM_INPUTS-1:0] active_d;
   logic [`NUM_INPUTS-1:0] active_q;

   generate
      for (gi = 0; gi < `NUM_INPUTS; gi++) begin : g_active
         // A selected input that has lost signal does not count as driving the PLL
         assign active_d[gi] = sel_valid_f && (sel_f == `SEL_W'(gi)) && !in_absent_s[gi];
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= '0;
      end else begin
         active_q <= active_d;
      end
   end

   assign active_status = active_q;

   // ---------------------------------------------------------------
   // Latched absent flags; a fresh alarm beats a clear in the same cycle
   logic [`ABSENT_W-1:0] latched_q;
   logic [`ABSENT_W-1:0] latched_d;
   logic [`ABSENT_W-1:0] latched_keep;

   // Writing 1 keeps a flag, writing 0 clears it
   assign latched_keep = wr_latched ? (latched_q & reg_wdata[`ABSENT_W-1:0]) : latched_q;
   assign latched_d = latched_keep | absent_live;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latched_q <= '0;
      end else begin
         latched_q <= latched_d;
      end
   end

   assign absent_latched = latched_q;

   // ---------------------------------------------------------------
   // Read path; active and live status bytes have no write decode so writes there are dropped
   logic [`DATA_W-1:0] rd_mux;
   logic [`DATA_W-1:0] rdata_q;
   logic [`DATA_W-1:0] rdata_d;
   byte_t band12_byte;
   byte_t band34_byte;

   assign band12_byte = pack_bands(band_q[1], band_q[0]);
   assign band34_byte = pack_bands(band_q[3], band_q[2]);

   // Unmapped addresses fall through to zero
   assign rd_mux =
      at_top ? {5'h00, div_top_q} :
      at_mid ? div_mid_q :
      at_low ? div_low_q :
      at_band12 ? band12_byte :
      at_band34 ? band34_byte :
      at_active ? {4'h0, active_q} :
      at_live ? {3'h0, absent_live} :
      at_latched ? {3'h0, latched_q} :
      8'h00;

   // Data holds only in the cycle after the strobe
   assign rdata_d = reg_rd ? rd_mux : 8'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : input_clock_monitor_regs

/* clkmon_props.sv */
// Port assertions and covers for the input clock monitor registers
`timescale 1ns/100ps
module clkmon_props
   import clkmon_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [18:0] input4_divider,
   input wire logic [2:0] input1_freq_band,
   input wire logic [2:0] input2_freq_band,
   input wire logic [2:0] input3_freq_band,
   input wire logic [2:0] input4_freq_band,
   input wire logic [3:0] active_status,
   input wire logic [4:0] absent_latched
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   a_active_read: assert property (reg_rd && reg_addr == 8'h80 |=> reg_rdata == {4'h0, $past(active_status)})
      else $error("active byte read wrong");
   a_div_low: assert property (reg_wr && reg_addr == 8'h36 |=> input4_divider[7:0] == $past(reg_wdata))
      else $error("divider low byte not written");
   a_div_mid: assert property (reg_wr && reg_addr == 8'h35 |=> input4_divider[15:8] == $past(reg_wdata))
      else $error("divider mid byte not written");
   a_div_top: assert property (reg_wr && reg_addr == 8'h34 |=> input4_divider[18:16] == $past(reg_wdata[2:0]))
      else $error("divider top bits not written");
   a_band_low: assert property (reg_wr && reg_addr == 8'h37 |=>
      {input2_freq_band, input1_freq_band} == $past(reg_wdata[5:0]))
      else $error("bands one and two misplaced");
   a_band_high: assert property (reg_wr && reg_addr == 8'h38 |=>
      {input4_freq_band, input3_freq_band} == $past(reg_wdata[5:0]))
      else $error("bands three and four misplaced");
   a_status_ro: assert property (reg_wr && reg_addr[7] |=> $stable(input4_divider) &&
      $stable({input4_freq_band, input3_freq_band, input2_freq_band, input1_freq_band}))
      else $error("status write changed configuration");
   a_active_one: assert property ($onehot0(active_status))
      else $error("more than one active input");
   a_latch_hold: assert property (!(reg_wr && reg_addr == 8'h83) |=>
      (absent_latched & $past(absent_latched)) == $past(absent_latched))
      else $error("latched flag dropped without clear");
   c_latched: cover property (absent_latched == 5'h1F);
   c_active: cover property (active_status != 4'h0);
   c_ro_write: cover property (reg_wr && reg_addr == 8'h80);
endmodule : clkmon_props

bind input_clock_monitor_regs clkmon_props clkmon_props_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .input4_divider(input4_divider), .input1_freq_band(input1_freq_band), .input2_freq_band(input2_freq_band),
   .input3_freq_band(input3_freq_band), .input4_freq_band(input4_freq_band),
   .active_status(active_status), .absent_latched(absent_latched));

/* host_model.sv */
// Host model driving the register port with one-cycle strobes
`timescale 1ns/100ps
module host_model
   import clkmon_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd
);
   initial begin
      reg_addr <= 8'h00;
      reg_wdata <= 8'h00;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
   end
   // Callers keep band codes at 5 or below
   task automatic wr(input byte_t a, input byte_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Data stand only in the cycle after the strobe; taken as that cycle closes
   task automatic rd(input byte_t a, output byte_t d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : host_model

/* input_clock_monitor_regs_test.sv */
// Self-checking bench for the input clock monitor registers
`timescale 1ns/100ps
`define SAME(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module input_clock_monitor_regs_test
   import clkmon_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   byte_t reg_addr, reg_wdata, reg_rdata;
   logic reg_wr, reg_rd, pll_input_valid, refclk_signal_absent;
   logic [1:0] selected_input;
   logic [3:0] input_signal_absent, band_legal, active_status;
   logic [18:0] input4_divider;
   logic [2:0] band1, band2, band3, band4;
   logic [4:0] absent_latched;
   int bad_count = 0;
   int checks = 0;
   always #5 clk = ~clk;
   host_model host_model_i (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   input_clock_monitor_regs input_clock_monitor_regs_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .selected_input(selected_input), .pll_input_valid(pll_input_valid),
      .input_signal_absent(input_signal_absent), .refclk_signal_absent(refclk_signal_absent),
      .input4_divider(input4_divider), .input1_freq_band(band1), .input2_freq_band(band2),
      .input3_freq_band(band3), .input4_freq_band(band4), .band_legal(band_legal),
      .active_status(active_status), .absent_latched(absent_latched));
   task automatic rchk(input byte_t a, input byte_t e);
      byte_t d;
      host_model_i.rd(a, d);
      `SAME(d, e)
   endtask : rchk
   task automatic wrap_up();
      if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      selected_input <= 2'h0;
      pll_input_valid <= 1'b0;
      input_signal_absent <= 4'h0;
      refclk_signal_absent <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rchk(8'h36, 8'h09);
      rchk(8'h35, 8'h00);
      host_model_i.wr(8'h34, 8'hFF);
      host_model_i.wr(8'h35, 8'hA5);
      host_model_i.wr(8'h36, 8'h5A);
      rchk(8'h34, 8'h07);
      `SAME(input4_divider, 19'h7A55A)
      // Reserved bits written as ones must still read back as zeros
      for (int c = 0; c < 6; c++) begin
         host_model_i.wr(8'h37, {2'h3, 3'(c), 3'(5 - c)});
         host_model_i.wr(8'h38, {2'h3, 3'(5 - c), 3'(c)});
         rchk(8'h37, {2'h0, 3'(c), 3'(5 - c)});
         rchk(8'h38, {2'h0, 3'(5 - c), 3'(c)});
         `SAME({band4, band3, band2, band1}, {3'(5 - c), 3'(c), 3'(c), 3'(5 - c)})
         `SAME(band_legal, 4'hF)
      end
      pll_input_valid <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         selected_input <= 2'(i);
         repeat (4) @(posedge clk);
         rchk(8'h80, 8'(1 << i));
         input_signal_absent <= 4'(1 << i);
         repeat (4) @(posedge clk);
         rchk(8'h80, 8'h00);
         rchk(8'h81, 8'(2 << i));
         input_signal_absent <= 4'h0;
      end
      refclk_signal_absent <= 1'b1;
      pll_input_valid <= 1'b0;
      repeat (4) @(posedge clk);
      rchk(8'h81, 8'h01);
      rchk(8'h80, 8'h00);
      `SAME(absent_latched, 5'h1F)
      refclk_signal_absent <= 1'b0;
      pll_input_valid <= 1'b1;
      repeat (2) @(posedge clk);
      host_model_i.wr(8'h83, 8'h00);
      @(negedge clk);
      `SAME(absent_latched, 5'h00)
      // Input four now drives the PLL; status writes must not disturb it
      host_model_i.wr(8'h80, 8'h00);
      host_model_i.wr(8'h81, 8'hFF);
      rchk(8'h80, 8'h08);
      rchk(8'h81, 8'h00);
      rchk(8'h50, 8'h00);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      `SAME(input4_divider, 19'h00009)
      `SAME({band4, band3, band2, band1}, 12'h000)
      `SAME(active_status, 4'h0)
      rst_n <= 1'b1;
      rchk(8'h36, 8'h09);
      rchk(8'h38, 8'h00);
      wrap_up();
   end
endmodule : input_clock_monitor_regs_test
